// ### hw/drvseq_pkg.sv
// Operation
// - State reported as code 0 to 7
// - Lowest numbered exit transition wins
// - Enter start disabled on power-up, restore
// - Trip condition moves live states to trip
// - Start disabled to start enabled when idle
// - Halt input false returns to start disabled
// - Go or inch moves to switched on
// - Switch open ten seconds trips
// - No go or inch returns start enabled
// - Switch closed and defluxed gives ready
// - Switch opening trips at once
// - Enabled: freewheel halt disables, quick halts
// - Enabled idle and stopped returns start enabled
// - Fast-stop ends on timer, freewheel, zero
// - Tripped clears on fault-clear rising edge
// - Remote mode takes inputs from command word
// - Bit 0 drives go; local go inputs ignored, inch stays local
// - Bit 1 ANDed with freewheel halt
// - Bit 2 ANDed with quick halt
// - Bit 3 ANDed with power stage permit
// - Bit 7 rising edge clears fault
package drvseq_pkg;

  // ****************************************
  // States
  // ****************************************
  typedef enum logic [2:0] {
    DRVSEQ_START_DIS = 3'h0,
    DRVSEQ_START_EN = 3'h1,
    DRVSEQ_SWITCHED_ON = 3'h2,
    DRVSEQ_READY = 3'h3,
    DRVSEQ_ENABLED = 3'h4,
    DRVSEQ_FSTOP = 3'h5,
    DRVSEQ_TRIP_ACT = 3'h6,
    DRVSEQ_TRIPPED = 3'h7
  } drvseq_state_t;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] DRVSEQ_CMD_OFS = 12'h000;
  localparam logic [11:0] DRVSEQ_CTRL_OFS = 12'h004;
  localparam logic [11:0] DRVSEQ_STAT_OFS = 12'h008;
  localparam logic [15:0] DRVSEQ_CMD_RST = 16'h047e;
  localparam int DRVSEQ_CMD_W = 16;

  localparam int DRVSEQ_B_GO = 0;
  localparam int DRVSEQ_B_FREEWHEEL = 1;
  localparam int DRVSEQ_B_QUICK = 2;
  localparam int DRVSEQ_B_ENABLE = 3;
  localparam int DRVSEQ_B_FCLR = 7;

  localparam int DRVSEQ_C_REMOTE = 0;
  localparam int DRVSEQ_C_RESTORE = 1;
  localparam int DRVSEQ_C_CFGMODE = 2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int DRVSEQ_CLK_HZ = 40000000;
  localparam int DRVSEQ_SW_WAIT_S = 10;
  localparam longint DRVSEQ_SW_WAIT_CYC =
    longint'(DRVSEQ_SW_WAIT_S) * longint'(DRVSEQ_CLK_HZ);

  // Merged sequencing inputs
  typedef struct packed {
    logic go;
    logic inch;
    logic freewheel_halt_n;
    logic quick_halt_n;
    logic enable;
    logic fault_clear;
  } drvseq_in_t;

endpackage : drvseq_pkg

// ### hw/drvseq_src_mux.sv
`timescale 1ns/10ps
module drvseq_src_mux
  import drvseq_pkg::*;
(
  input wire logic remote,
  input wire logic [15:0] cmd,
  input wire logic forward_go,
  input wire logic reverse_go,
  input wire logic held_go,
  input wire logic inch_request,
  input wire logic freewheel_halt_n,
  input wire logic quick_halt_n,
  input wire logic power_stage_permit,
  input wire logic remote_fault_clear,
  output drvseq_in_t sel
);
  // ****************************************
  // Source selection
  // ****************************************
  always_comb
  begin
    sel = '0;
    if (remote)
    begin
      sel.go = cmd[DRVSEQ_B_GO];
      sel.inch = inch_request;
      sel.freewheel_halt_n = cmd[DRVSEQ_B_FREEWHEEL] & freewheel_halt_n;
      sel.quick_halt_n = cmd[DRVSEQ_B_QUICK] & quick_halt_n;
      sel.enable = cmd[DRVSEQ_B_ENABLE] & power_stage_permit;
      sel.fault_clear = cmd[DRVSEQ_B_FCLR];
    end
    else
    begin
      sel.go = forward_go | reverse_go | held_go;
      sel.inch = inch_request;
      sel.freewheel_halt_n = freewheel_halt_n;
      sel.quick_halt_n = quick_halt_n;
      sel.enable = power_stage_permit;
      sel.fault_clear = remote_fault_clear;
    end
  end
endmodule : drvseq_src_mux

// ### hw/drvseq_top.sv
`timescale 1ns/10ps
module drvseq_top
  import drvseq_pkg::*;
#(
  parameter longint SW_WAIT_CYC = DRVSEQ_SW_WAIT_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic forward_go,
  input wire logic reverse_go,
  input wire logic held_go,
  input wire logic inch_request,
  input wire logic freewheel_halt_n,
  input wire logic quick_halt_n,
  input wire logic power_stage_permit,
  input wire logic remote_fault_clear,
  input wire logic trip_cond,
  input wire logic output_switch_closed,
  input wire logic defluxed,
  input wire logic stop_done,
  input wire logic quick_halt_timeout,
  input wire logic quick_halt_style,
  input wire logic zero_setpoint,
  input wire logic stack_quenched,
  output logic [2:0] seq_state_code
);

  // Counter must reach the wait figure
  if (SW_WAIT_CYC < 1 || SW_WAIT_CYC > 64'h0000_0000_ffff_ffff)
  begin : g_bad_wait
    $error("SW_WAIT_CYC out of range");
  end

  // ****************************************
  // Registers
  // ****************************************
  drvseq_state_t state_r, state_nxt;
  logic [15:0] cmd_r, cmd_nxt;
  logic [2:0] ctrl_r, ctrl_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] wait_r, wait_nxt;
  logic fclr_r, fclr_nxt;
  logic restore_r, restore_nxt;
  logic cfg_exit_r, cfg_exit_nxt;
  drvseq_in_t in_s;
  logic setup, access_phase, wr_ok;
  logic fclr_rise, sw_timeout;

  assign setup = psel & ~penable;
  assign access_phase = psel & penable;

  function automatic logic map_hit(input logic [11:0] a);
    map_hit = (a == DRVSEQ_CMD_OFS) || (a == DRVSEQ_CTRL_OFS) ||
      (a == DRVSEQ_STAT_OFS);
  endfunction : map_hit

  drvseq_src_mux u_mux (
    .remote(ctrl_r[DRVSEQ_C_REMOTE]),
    .cmd(cmd_r),
    .forward_go(forward_go),
    .reverse_go(reverse_go),
    .held_go(held_go),
    .inch_request(inch_request),
    .freewheel_halt_n(freewheel_halt_n),
    .quick_halt_n(quick_halt_n),
    .power_stage_permit(power_stage_permit),
    .remote_fault_clear(remote_fault_clear),
    .sel(in_s)
  );

  // ****************************************
  // APB slave: no wait states, answer on access
  // ****************************************
  always_comb
  begin
    cmd_nxt = cmd_r;
    ctrl_nxt = ctrl_r;
    prdata_nxt = prdata_r;
    pready_nxt = 1'b0;
    pslverr_nxt = 1'b0;
    restore_nxt = 1'b0;
    cfg_exit_nxt = 1'b0;
    wr_ok = access_phase & pready_r & pwrite & ~pslverr_r;
    if (setup)
    begin
      pready_nxt = 1'b1;
      pslverr_nxt = ~map_hit(paddr);
      prdata_nxt = '0;
      case (paddr)
        DRVSEQ_CMD_OFS: prdata_nxt = {16'h0000, cmd_r};
        DRVSEQ_CTRL_OFS: prdata_nxt = {29'h0, ctrl_r & 3'h5};
        DRVSEQ_STAT_OFS: prdata_nxt = {29'h0, state_r};
        default: prdata_nxt = '0;
      endcase
    end
    if (wr_ok)
    begin
      case (paddr)
        DRVSEQ_CMD_OFS: cmd_nxt = pwdata[15:0];
        DRVSEQ_CTRL_OFS:
        begin
          ctrl_nxt = pwdata[2:0] & 3'h5;
          // Restore is a pulse, never stored
          restore_nxt = pwdata[DRVSEQ_C_RESTORE];
          cfg_exit_nxt = ctrl_r[DRVSEQ_C_CFGMODE] &
            ~pwdata[DRVSEQ_C_CFGMODE];
        end
        default: cmd_nxt = cmd_r;
      endcase
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  assign fclr_rise = in_s.fault_clear & ~fclr_r;
  assign sw_timeout = (longint'(wait_r) >= SW_WAIT_CYC - 1);
  assign fclr_nxt = in_s.fault_clear;

  always_comb
  begin
    state_nxt = state_r;
    wait_nxt = '0;
    // Checks in order give the lowest number first
    case (state_r)
      DRVSEQ_START_DIS:
        if (trip_cond)
          state_nxt = DRVSEQ_TRIP_ACT;
        else if (!in_s.go && !in_s.inch && in_s.quick_halt_n &&
                 in_s.freewheel_halt_n)
          state_nxt = DRVSEQ_START_EN;
      DRVSEQ_START_EN:
        if (trip_cond)
          state_nxt = DRVSEQ_TRIP_ACT;
        else if (!in_s.freewheel_halt_n || !in_s.quick_halt_n)
          state_nxt = DRVSEQ_START_DIS;
        else if (in_s.go || in_s.inch)
          state_nxt = DRVSEQ_SWITCHED_ON;
      DRVSEQ_SWITCHED_ON:
      begin
        // Time the switch only while it stays open
        if (!output_switch_closed)
          wait_nxt = wait_r + 32'h1;
        if (trip_cond || (!output_switch_closed && sw_timeout))
          state_nxt = DRVSEQ_TRIP_ACT;
        else if (!in_s.freewheel_halt_n || !in_s.quick_halt_n)
          state_nxt = DRVSEQ_START_DIS;
        else if (!in_s.go && !in_s.inch)
          state_nxt = DRVSEQ_START_EN;
        else if (output_switch_closed && defluxed)
          state_nxt = DRVSEQ_READY;
      end
      DRVSEQ_READY:
        if (trip_cond || !output_switch_closed)
          state_nxt = DRVSEQ_TRIP_ACT;
        else if (!in_s.freewheel_halt_n || !in_s.quick_halt_n)
          state_nxt = DRVSEQ_START_DIS;
        else if (!in_s.go && !in_s.inch)
          state_nxt = DRVSEQ_START_EN;
        else if (in_s.enable)
          state_nxt = DRVSEQ_ENABLED;
      DRVSEQ_ENABLED:
        if (trip_cond || !output_switch_closed)
          state_nxt = DRVSEQ_TRIP_ACT;
        else if (!in_s.freewheel_halt_n)
          state_nxt = DRVSEQ_START_DIS;
        else if (!in_s.quick_halt_n)
          state_nxt = DRVSEQ_FSTOP;
        else if (!in_s.go && !in_s.inch && stop_done)
          state_nxt = DRVSEQ_START_EN;
        else if (!in_s.enable)
          state_nxt = DRVSEQ_READY;
      DRVSEQ_FSTOP:
        if (trip_cond || !output_switch_closed)
          state_nxt = DRVSEQ_TRIP_ACT;
        else if (quick_halt_timeout || quick_halt_style || zero_setpoint)
          state_nxt = DRVSEQ_START_DIS;
      DRVSEQ_TRIP_ACT:
        if (stack_quenched)
          state_nxt = DRVSEQ_TRIPPED;
      DRVSEQ_TRIPPED:
        if (!trip_cond && fclr_rise)
          state_nxt = DRVSEQ_START_DIS;
      default: state_nxt = DRVSEQ_START_DIS;
    endcase
    if (restore_r || cfg_exit_r)
    begin
      state_nxt = DRVSEQ_START_DIS;
      wait_nxt = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= DRVSEQ_START_DIS;
      cmd_r <= DRVSEQ_CMD_RST;
      ctrl_r <= '0;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      wait_r <= '0;
      fclr_r <= 1'b0;
      restore_r <= 1'b0;
      cfg_exit_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      ctrl_r <= ctrl_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      wait_r <= wait_nxt;
      fclr_r <= fclr_nxt;
      restore_r <= restore_nxt;
      cfg_exit_r <= cfg_exit_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign seq_state_code = state_r;

endmodule : drvseq_top

// ### sim/drvseq_props.sv
`timescale 1ns/10ps
module drvseq_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic freewheel_halt_n,
  input wire logic quick_halt_style,
  input wire logic trip_cond,
  input wire logic output_switch_closed,
  input wire logic stack_quenched,
  input wire logic [2:0] seq_state_code
);
  // **********
  // Checks
  // **********
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic sw_ok;
  logic [2:0] s;
  // Halt exits only count once trip exits are ruled out
  assign sw_ok = !trip_cond && output_switch_closed;
  assign s = seq_state_code;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_done;
    psel && penable && pready ##1 !pready;
  endsequence
  property p_ack;
    s_setup |=> s_done;
  endproperty
  a_ack: assert property (p_ack) else $error("late ack");
  property p_trip;
    trip_cond && s < 3'h6 |=> s == 3'h6;
  endproperty
  a_trip: assert property (p_trip) else $error("no trip");
  property p_quench;
    s == 3'h6 && stack_quenched |=> s == 3'h7;
  endproperty
  a_quench: assert property (p_quench) else $error("no trip");
  property p_hold;
    s == 3'h7 && trip_cond |=> s == 3'h7;
  endproperty
  a_hold: assert property (p_hold) else $error("left trip");
  property p_sw;
    s inside {3'h3, 3'h4, 3'h5} && !output_switch_closed |=> s == 3'h6;
  endproperty
  a_sw: assert property (p_sw) else $error("no trip");
  property p_halt;
    s inside {3'h1, 3'h2, 3'h3} && sw_ok && !freewheel_halt_n
      |=> s == 3'h0;
  endproperty
  a_halt: assert property (p_halt) else $error("no halt");
  property p_coast;
    s == 3'h4 && sw_ok && !freewheel_halt_n |=> s == 3'h0;
  endproperty
  a_coast: assert property (p_coast) else $error("no coast");
  property p_style;
    s == 3'h5 && sw_ok && quick_halt_style |=> s == 3'h0;
  endproperty
  a_style: assert property (p_style) else $error("no stop");
endmodule : drvseq_props
bind drvseq_top drvseq_props u_props (.*);

// ### sim/drvseq_apb_master.sv
`timescale 1ns/10ps
module drvseq_apb_master
  import drvseq_pkg::*;
(
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  // **********
  // Register reader and writer
  // **********
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [32:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= (a == DRVSEQ_CMD_OFS) ? ((d & 32'h8f) | 32'h470) : d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a hung wait
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    q = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines must not look valid
    paddr <= ~a;
    pwdata <= ~pwdata;
  endtask : xfer
endmodule : drvseq_apb_master

// ### sim/drvseq_bench.sv
`timescale 1ns/10ps
module drvseq_bench
  import drvseq_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0;
  logic forward_go = 1'b0, reverse_go = 1'b0, held_go = 1'b0;
  logic inch_request = 1'b0, freewheel_halt_n = 1'b0;
  logic quick_halt_n = 1'b1, power_stage_permit = 1'b0;
  logic remote_fault_clear = 1'b0, trip_cond = 1'b0;
  logic output_switch_closed = 1'b0, defluxed = 1'b1;
  logic stop_done = 1'b0, quick_halt_timeout = 1'b0;
  logic quick_halt_style = 1'b0, zero_setpoint = 1'b0;
  logic stack_quenched = 1'b0, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] seq_state_code;
  logic [32:0] q;
  int err_total = 0, comparisons = 0, cyc = 0;
  // **********
  // Harness
  // **********
  drvseq_top #(.SW_WAIT_CYC(20)) u_dut (.*);
  drvseq_apb_master u_mst (.*);
  always #12.5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      err_total++;
      finish_test();
    end
  end
  task automatic finish_test;
    $display("mismatches %0d checks %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [32:0] s,
    input logic [32:0] e);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, s);
    end
  endtask : chk
  // Tolerant of latency; every checked state but switched on with the switch open is a resting one
  task automatic st(input logic [2:0] e);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk("state", {30'h0, seq_state_code}, {30'h0, e});
  endtask : st
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_mst.xfer(1'b1, a, d, q);
  endtask : wr
  // **********
  // Scenarios
  // **********
  task automatic t_walk;
    st(3'h0);
    @(posedge pclk) freewheel_halt_n <= 1'b1;
    st(3'h1);
    @(posedge pclk) forward_go <= 1'b1;
    st(3'h2);
    @(posedge pclk) output_switch_closed <= 1'b1;
    st(3'h3);
    @(posedge pclk) power_stage_permit <= 1'b1;
    st(3'h4);
    @(posedge pclk) power_stage_permit <= 1'b0;
    st(3'h3);
    @(posedge pclk) power_stage_permit <= 1'b1;
    @(posedge pclk) forward_go <= 1'b0;
    st(3'h4);
    @(posedge pclk) stop_done <= 1'b1;
    st(3'h1);
    @(posedge pclk) forward_go <= 1'b1;
    st(3'h4);
    @(posedge pclk) quick_halt_n <= 1'b0;
    st(3'h5);
    @(posedge pclk) quick_halt_style <= 1'b1;
    st(3'h0);
    @(posedge pclk) quick_halt_n <= 1'b1;
    st(3'h0);
    @(posedge pclk) forward_go <= 1'b0;
    @(posedge pclk) forward_go <= 1'b1;
    st(3'h4);
    @(posedge pclk) freewheel_halt_n <= 1'b0;
    st(3'h0);
  endtask : t_walk
  task automatic t_trip;
    @(posedge pclk) freewheel_halt_n <= 1'b1;
    forward_go <= 1'b0;
    @(posedge pclk) forward_go <= 1'b1;
    st(3'h4);
    @(posedge pclk) trip_cond <= 1'b1;
    st(3'h6);
    @(posedge pclk) stack_quenched <= 1'b1;
    st(3'h7);
    @(posedge pclk) remote_fault_clear <= 1'b1;
    st(3'h7);
    @(posedge pclk) trip_cond <= 1'b0;
    remote_fault_clear <= 1'b0;
    forward_go <= 1'b0;
    st(3'h7);
    @(posedge pclk) remote_fault_clear <= 1'b1;
    st(3'h1);
  endtask : t_trip
  task automatic t_prio;
    @(posedge pclk) inch_request <= 1'b1;
    freewheel_halt_n <= 1'b0;
    st(3'h0);
    @(posedge pclk) inch_request <= 1'b0;
    freewheel_halt_n <= 1'b1;
    @(posedge pclk) output_switch_closed <= 1'b0;
    stack_quenched <= 1'b0;
    inch_request <= 1'b1;
    st(3'h2);
    // Wait of 20: still switched on after 19 open cycles
    repeat (17) @(posedge pclk);
    @(negedge pclk);
    chk("sw_wait", {30'h0, seq_state_code}, {30'h0, 3'h2});
    @(negedge pclk);
    chk("sw_trip", {30'h0, seq_state_code}, {30'h0, 3'h6});
  endtask : t_prio
  task automatic t_remote;
    @(posedge pclk) stack_quenched <= 1'b1;
    inch_request <= 1'b0;
    output_switch_closed <= 1'b1;
    remote_fault_clear <= 1'b0;
    u_mst.xfer(1'b0, DRVSEQ_CMD_OFS, 32'h0, q);
    chk("cmd", q, {17'h0, DRVSEQ_CMD_RST});
    u_mst.xfer(1'b0, 12'h00c, 32'h0, q);
    chk("unmapped", q, {1'b1, 32'h0});
    wr(DRVSEQ_CTRL_OFS, 32'h1);
    wr(DRVSEQ_CMD_OFS, 32'h0);
    wr(DRVSEQ_CMD_OFS, 32'h80);
    st(3'h0);
    wr(DRVSEQ_CMD_OFS, 32'h6);
    st(3'h1);
    @(posedge pclk) power_stage_permit <= 1'b0;
    forward_go <= 1'b1;
    wr(DRVSEQ_CMD_OFS, 32'h047f);
    st(3'h3);
    @(posedge pclk) power_stage_permit <= 1'b1;
    st(3'h4);
    wr(DRVSEQ_CMD_OFS, 32'h047e);
    st(3'h1);
    wr(DRVSEQ_CMD_OFS, 32'h047f);
    st(3'h4);
    @(posedge pclk) output_switch_closed <= 1'b0;
    st(3'h7);
    @(posedge pclk) output_switch_closed <= 1'b1;
    wr(DRVSEQ_CTRL_OFS, 32'h3);
    st(3'h0);
    u_mst.xfer(1'b0, DRVSEQ_CTRL_OFS, 32'h0, q);
    chk("ctrl", q, 33'h1);
    u_mst.xfer(1'b0, DRVSEQ_STAT_OFS, 32'h0, q);
    chk("status", q, 33'h0);
  endtask : t_remote
  task automatic t_modes;
    wr(DRVSEQ_CMD_OFS, 32'h047e);
    wr(DRVSEQ_CMD_OFS, 32'h047f);
    st(3'h4);
    wr(DRVSEQ_CTRL_OFS, 32'h5);
    st(3'h4);
    wr(DRVSEQ_CTRL_OFS, 32'h1);
    st(3'h0);
    u_mst.xfer(1'b0, DRVSEQ_CTRL_OFS, 32'h0, q);
    chk("cfg_ctrl", q, 33'h1);
    // Local go inputs must not leak into remote mode
    @(posedge pclk) reverse_go <= 1'b1;
    held_go <= 1'b1;
    wr(DRVSEQ_CMD_OFS, 32'h047e);
    st(3'h1);
    @(posedge pclk) forward_go <= 1'b0;
    held_go <= 1'b0;
    wr(DRVSEQ_CTRL_OFS, 32'h0);
    st(3'h4);
    @(posedge pclk) reverse_go <= 1'b0;
    st(3'h1);
    @(posedge pclk) held_go <= 1'b1;
    st(3'h4);
    @(posedge pclk) power_stage_permit <= 1'b0;
    st(3'h3);
    @(posedge pclk) held_go <= 1'b0;
    st(3'h1);
    @(posedge pclk) defluxed <= 1'b0;
    held_go <= 1'b1;
    st(3'h2);
    @(posedge pclk) held_go <= 1'b0;
    st(3'h1);
    @(posedge pclk) defluxed <= 1'b1;
    power_stage_permit <= 1'b1;
    quick_halt_style <= 1'b0;
    held_go <= 1'b1;
    st(3'h4);
    @(posedge pclk) quick_halt_n <= 1'b0;
    st(3'h5);
    @(posedge pclk) quick_halt_timeout <= 1'b1;
    st(3'h0);
    @(posedge pclk) quick_halt_timeout <= 1'b0;
    quick_halt_n <= 1'b1;
    held_go <= 1'b0;
    @(posedge pclk) held_go <= 1'b1;
    st(3'h4);
    @(posedge pclk) quick_halt_n <= 1'b0;
    st(3'h5);
    @(posedge pclk) zero_setpoint <= 1'b1;
    st(3'h0);
    @(posedge pclk) zero_setpoint <= 1'b0;
    quick_halt_n <= 1'b1;
  endtask : t_modes
  task automatic t_reset;
    wr(DRVSEQ_CMD_OFS, 32'h047f);
    @(posedge pclk) presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk("rst_state", {30'h0, seq_state_code}, 33'h0);
    @(posedge pclk) presetn <= 1'b1;
    u_mst.xfer(1'b0, DRVSEQ_CMD_OFS, 32'h0, q);
    chk("rst_cmd", q, {17'h0, DRVSEQ_CMD_RST});
    u_mst.xfer(1'b0, DRVSEQ_CTRL_OFS, 32'h0, q);
    chk("rst_ctrl", q, 33'h0);
    st(3'h0);
  endtask : t_reset
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_walk();
    t_trip();
    t_prio();
    t_remote();
    t_modes();
    t_reset();
    finish_test();
  end
endmodule : drvseq_bench
